// ==== ctf_pkg.sv ====
package ctf_pkg;

  // Clock
  localparam int unsigned CLK_PERIOD_NS = 10;

  // Timeouts in their own unit, converted to clock cycles (least times, rounded up)
  localparam int unsigned TX_LOW_TIMEOUT_NS   = 1000000;
  localparam int unsigned BUS_HOLD_TIMEOUT_NS = 1000000;
  localparam int unsigned TX_LOW_TIMEOUT_CYC   = (TX_LOW_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BUS_HOLD_TIMEOUT_CYC = (BUS_HOLD_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Consecutive dominant cycles with the receive pin high before the receive fault
  localparam logic [2:0] RX_STUCK_CYCLES = 3'h7;

  // Bus geometry
  localparam int unsigned WB_AW = 8;
  localparam int unsigned WB_DW = 32;

  // Register byte addresses
  localparam logic [WB_AW-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [WB_AW-1:0] ADDR_STATUS = 8'h04;
  localparam logic [WB_AW-1:0] ADDR_MASK   = 8'h08;
  localparam logic [WB_AW-1:0] ADDR_STATE  = 8'h0C;

  // Control register fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_INH_BIT  = 2;

  // Operating mode field
  typedef enum logic [1:0] {
    MODE_SLEEP_NOWAKE = 2'h0,
    MODE_LISTEN       = 2'h1,
    MODE_SLEEP_WAKE   = 2'h2,
    MODE_NORMAL       = 2'h3
  } ctf_mode_t;

  localparam ctf_mode_t MODE_RESET = MODE_SLEEP_WAKE;

  // Fault flags, bit 0 upward: tx low, rx high, bus dominant, then four shorts
  typedef struct packed {
    logic canl_gnd;
    logic canl_batt;
    logic canh_gnd;
    logic canh_batt;
    logic bus_dom;
    logic rx_high;
    logic tx_low;
  } ctf_flags_t;

  localparam int unsigned FLAG_W = 7;
  localparam logic [FLAG_W-1:0] ERROR_CLASS = 7'h07;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 7'h00;

  // Short comparator inputs from the analog front end
  typedef struct packed {
    logic canl_gnd;
    logic canl_batt;
    logic canh_gnd;
    logic canh_batt;
  } ctf_short_t;

  // Live state register fields
  localparam int unsigned ST_MODE_LSB = 0;
  localparam int unsigned ST_LOW_POWER_OFF_STATE    = 2;
  localparam int unsigned ST_DRV      = 3;
  localparam int unsigned ST_RX       = 4;
  localparam int unsigned ST_TXLOCK   = 5;
  localparam int unsigned ST_RXLOCK   = 6;

endpackage

// ==== ctf_timeout.sv ====
`timescale 1ns/1ps
`default_nettype none
module ctf_timeout #(
  parameter int unsigned LIMIT = 16,
  parameter int unsigned W     = $clog2(LIMIT + 1)
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Count control
  input  wire logic run,
  output logic      expired
);

  logic [W-1:0] cnt_q;

  // Counts run cycles, holds at the limit, clears when run drops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (!run) begin
      cnt_q <= '0;
    end else if (cnt_q != W'(LIMIT)) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // One pulse when run has lasted the full limit
  assign expired = run && (cnt_q == W'(LIMIT - 1));

endmodule // ctf_timeout
`default_nettype wire

// ==== ctf_ctrl.sv ====
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ctf_ctrl #(
  parameter int unsigned TX_TIMEOUT_CYC  = ctf_pkg::TX_LOW_TIMEOUT_CYC,
  parameter int unsigned BUS_TIMEOUT_CYC = ctf_pkg::BUS_HOLD_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic                      CLK,
  input  wire logic                      RST,
  // Wishbone slave
  input  wire logic                      WB_CYC_I,
  input  wire logic                      WB_STB_I,
  input  wire logic                      WB_WE_I,
  input  wire logic [ctf_pkg::WB_AW-1:0] WB_ADR_I,
  input  wire logic [3:0]                WB_SEL_I,
  input  wire logic [ctf_pkg::WB_DW-1:0] WB_DAT_I,
  output logic      [ctf_pkg::WB_DW-1:0] WB_DAT_O,
  output logic                           WB_ACK_O,
  // Chip state and controller pins
  input  wire logic                      LOW_POWER_OFF_STATE,
  input  wire logic                      TXD,
  input  wire logic                      RXD_SENSE,
  output logic                           RXD,
  output logic                           TXD_PULLDOWN,
  output logic                           RXD_PULLDOWN,
  // Analog front end
  input  wire logic                      BUS_DOMINANT,
  input  wire ctf_pkg::ctf_short_t       SHORTS,
  output logic                           DRV_EN,
  output logic                           RX_EN,
  output logic                           BUS_INPUT_PULLDOWN,
  // Interrupt
  output logic                           INT
);
  import ctf_pkg::*;

  ctf_mode_t         mode_q;
  ctf_mode_t         saved_q;
  logic              inhibit_q;
  ctf_flags_t        status_q;
  logic [FLAG_W-1:0] mask_q;
  logic              low_power_off_state_q;
  logic              tx_lock_q;
  logic              rx_lock_q;
  logic              txd_q;
  logic              rx_seen_low_q;
  logic [2:0]        rx_cnt_q;
  logic              ack_q;
  logic [WB_DW-1:0]  dat_q;
  logic              drv_q;
  logic              rxen_q;
  logic              rxd_q;
  logic              low_power_off_state_out_q;
  logic              int_q;

  logic              wr_ctrl;
  logic              wr_status;
  logic              wr_mask;
  logic              bus_req;
  logic              supervise;
  logic              lp_enter;
  logic              lp_exit;
  logic              tx_expired;
  logic              bus_expired;
  logic              rx_fault;
  logic              dom_end;
  logic              drv_ok;
  logic              rx_ok;
  ctf_flags_t        set_flags;
  logic [FLAG_W-1:0] clr_flags;
  logic [WB_DW-1:0]  rd_data;

  // Bus write strobes at the edge where the master samples ack
  assign bus_req   = WB_CYC_I && WB_STB_I;
  assign wr_ctrl   = bus_req && ack_q && WB_WE_I && WB_SEL_I[0] && (WB_ADR_I == ADDR_CTRL);
  assign wr_status = bus_req && ack_q && WB_WE_I && WB_SEL_I[0] && (WB_ADR_I == ADDR_STATUS);
  assign wr_mask   = bus_req && ack_q && WB_WE_I && WB_SEL_I[0] && (WB_ADR_I == ADDR_MASK);

  // Low-power-off edges
  assign lp_enter = LOW_POWER_OFF_STATE && !low_power_off_state_q;
  assign lp_exit  = !LOW_POWER_OFF_STATE && low_power_off_state_q;

  // Supervision window
  assign supervise = !LOW_POWER_OFF_STATE && ((mode_q == MODE_NORMAL) || (mode_q == MODE_LISTEN));

  // Timeout counters
  ctf_timeout #(
    .LIMIT (TX_TIMEOUT_CYC)
  ) u_tx_timeout (
    .clk     (CLK),
    .rst     (RST),
    .run     (supervise && !TXD && !tx_lock_q),
    .expired (tx_expired)
  );

  ctf_timeout #(
    .LIMIT (BUS_TIMEOUT_CYC)
  ) u_bus_timeout (
    .clk     (CLK),
    .rst     (RST),
    .run     (supervise && BUS_DOMINANT),
    .expired (bus_expired)
  );

  // Receive stuck check: one dominant cycle ends when the transmit input rises
  assign dom_end  = TXD && !txd_q;
  assign rx_fault = supervise && dom_end && !rx_seen_low_q && !rx_lock_q
                    && (rx_cnt_q == RX_STUCK_CYCLES - 3'h1);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      txd_q         <= 1'b1;
      rx_seen_low_q <= 1'b0;
      rx_cnt_q      <= 3'h0;
    end else begin
      txd_q <= TXD;
      if (!supervise) begin
        rx_seen_low_q <= 1'b0;
        rx_cnt_q      <= 3'h0;
      end else if (!TXD && txd_q) begin
        rx_seen_low_q <= !RXD_SENSE;
      end else if (!TXD && !RXD_SENSE) begin
        rx_seen_low_q <= 1'b1;
      end else if (dom_end) begin
        if (rx_seen_low_q || rx_fault) begin
          rx_cnt_q <= 3'h0;
        end else begin
          rx_cnt_q <= rx_cnt_q + 3'h1;
        end
      end
    end
  end

  // Mode field with low-power-off save and restore and fault MSB clear
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mode_q  <= MODE_RESET;
      saved_q <= MODE_RESET;
      low_power_off_state_q <= 1'b0;
    end else begin
      low_power_off_state_q <= LOW_POWER_OFF_STATE;
      if (lp_enter) begin
        saved_q <= mode_q;
        if (mode_q != MODE_SLEEP_NOWAKE) begin
          mode_q <= MODE_SLEEP_WAKE;
        end
      end else if (lp_exit) begin
        mode_q <= saved_q;
      end else if (tx_expired || rx_fault) begin
        mode_q <= ctf_mode_t'({1'b0, mode_q[0]});
      end else if (wr_ctrl && !LOW_POWER_OFF_STATE) begin
        mode_q <= ctf_mode_t'(WB_DAT_I[CTRL_MODE_LSB +: 2]);
      end
    end
  end

  // Fault locks
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tx_lock_q <= 1'b0;
      rx_lock_q <= 1'b0;
    end else begin
      if (tx_expired) begin
        tx_lock_q <= 1'b1;
      end else if (tx_lock_q && mode_q == MODE_NORMAL && TXD) begin
        tx_lock_q <= 1'b0;
      end
      if (rx_fault) begin
        rx_lock_q <= 1'b1;
      end else if (wr_ctrl && !LOW_POWER_OFF_STATE
                   && WB_DAT_I[CTRL_MODE_LSB +: 2] == MODE_NORMAL) begin
        rx_lock_q <= 1'b0;
      end
    end
  end

  // Pin and front-end controls
  assign drv_ok = !LOW_POWER_OFF_STATE && mode_q == MODE_NORMAL && !tx_lock_q && !rx_lock_q;
  assign rx_ok  = !LOW_POWER_OFF_STATE && (mode_q == MODE_NORMAL || mode_q == MODE_LISTEN) && !rx_lock_q;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      drv_q       <= 1'b0;
      rxen_q      <= 1'b0;
      rxd_q       <= 1'b1;
      low_power_off_state_out_q <= 1'b0;
    end else begin
      drv_q       <= drv_ok && !TXD && !tx_expired && !rx_fault;
      rxen_q      <= rx_ok && !rx_fault;
      rxd_q       <= LOW_POWER_OFF_STATE ? 1'b0 : (rx_ok ? !BUS_DOMINANT : 1'b1);
      low_power_off_state_out_q <= LOW_POWER_OFF_STATE;
    end
  end

  // Fault flags, set wins over write-one-to-clear
  always_comb begin
    set_flags           = '0;
    set_flags.tx_low    = tx_expired;
    set_flags.rx_high   = rx_fault;
    set_flags.bus_dom   = bus_expired;
    set_flags.canh_batt = (mode_q == MODE_NORMAL) && !LOW_POWER_OFF_STATE && SHORTS.canh_batt;
    set_flags.canh_gnd  = (mode_q == MODE_NORMAL) && !LOW_POWER_OFF_STATE && SHORTS.canh_gnd;
    set_flags.canl_batt = (mode_q == MODE_NORMAL) && !LOW_POWER_OFF_STATE && SHORTS.canl_batt;
    set_flags.canl_gnd  = (mode_q == MODE_NORMAL) && !LOW_POWER_OFF_STATE && SHORTS.canl_gnd;
  end

  assign clr_flags = wr_status ? WB_DAT_I[FLAG_W-1:0] : '0;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      status_q  <= FLAGS_RESET;
      mask_q    <= FLAGS_RESET;
      inhibit_q <= 1'b0;
    end else begin
      status_q <= (status_q & ~clr_flags) | set_flags;
      if (wr_mask) begin
        mask_q <= WB_DAT_I[FLAG_W-1:0];
      end
      if (wr_ctrl) begin
        inhibit_q <= WB_DAT_I[CTRL_INH_BIT];
      end
    end
  end

  // Interrupt from unmasked error-class flags only
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      int_q <= 1'b0;
    end else begin
      int_q <= !inhibit_q && (|(status_q & mask_q & ERROR_CLASS));
    end
  end

  // Read mux
  always_comb begin
    rd_data = '0;
    if (WB_ADR_I == ADDR_CTRL) begin
      rd_data[CTRL_MODE_LSB +: 2] = mode_q;
      rd_data[CTRL_INH_BIT]       = inhibit_q;
    end else if (WB_ADR_I == ADDR_STATUS) begin
      rd_data[FLAG_W-1:0] = status_q;
    end else if (WB_ADR_I == ADDR_MASK) begin
      rd_data[FLAG_W-1:0] = mask_q;
    end else if (WB_ADR_I == ADDR_STATE) begin
      rd_data[ST_MODE_LSB +: 2] = mode_q;
      rd_data[ST_LOW_POWER_OFF_STATE]         = LOW_POWER_OFF_STATE;
      rd_data[ST_DRV]           = drv_q;
      rd_data[ST_RX]            = rxen_q;
      rd_data[ST_TXLOCK]        = tx_lock_q;
      rd_data[ST_RXLOCK]        = rx_lock_q;
    end
  end

  // Wishbone handshake: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= bus_req && !ack_q;
      if (bus_req && !ack_q) begin
        dat_q <= rd_data;
      end
    end
  end

  assign WB_ACK_O           = ack_q;
  assign WB_DAT_O           = dat_q;
  assign DRV_EN             = drv_q;
  assign RX_EN              = rxen_q;
  assign RXD                = rxd_q;
  assign RXD_PULLDOWN       = low_power_off_state_out_q;
  assign TXD_PULLDOWN       = low_power_off_state_out_q;
  assign BUS_INPUT_PULLDOWN = low_power_off_state_out_q;
  assign INT                = int_q;

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_normal_drive_on: assert property (
    (drv_ok && !TXD && !tx_expired && !rx_fault) |=> DRV_EN
  ) else $error("drivers not on for low transmit input in normal mode");

  a_listen_no_drive: assert property (
    (mode_q == MODE_LISTEN) |=> !DRV_EN
  ) else $error("driver active in listen-only mode");

  a_low_power_off_state_all_off: assert property (
    LOW_POWER_OFF_STATE |=> (!DRV_EN && !RX_EN && !RXD && BUS_INPUT_PULLDOWN && TXD_PULLDOWN)
  ) else $error("transceiver not asleep in low-power-off");

  a_low_power_off_state_enter_mode: assert property (
    (lp_enter && mode_q != MODE_SLEEP_NOWAKE) |=> (mode_q == MODE_SLEEP_WAKE)
  ) else $error("mode not forced to sleep with wake-up on entry");

  a_low_power_off_state_exit_mode: assert property (
    (low_power_off_state_q && !LOW_POWER_OFF_STATE) |=> (mode_q == $past(saved_q))
  ) else $error("mode not restored on leaving low-power-off");

  a_tx_timeout_fault: assert property (
    tx_expired |=> (!mode_q[1] && status_q.tx_low && !DRV_EN && tx_lock_q)
  ) else $error("transmit timeout not handled");

  a_tx_sleep_quiet: assert property (
    (mode_q == MODE_SLEEP_WAKE || mode_q == MODE_SLEEP_NOWAKE) |-> !tx_expired && !rx_fault
  ) else $error("supervision active outside normal and listen-only");

  a_rx_stuck_off: assert property (
    rx_fault |=> ##1 (!DRV_EN && !RX_EN && !mode_q[1]) [*2]
  ) else $error("receive stuck fault did not shut transceiver");

  a_bus_dom_flag: assert property (
    bus_expired |=> status_q.bus_dom
  ) else $error("bus dominant flag not set");

  a_short_normal_only: assert property (
    ((status_q & ~$past(status_q) & ~ERROR_CLASS) != FLAGS_RESET) |-> $past(mode_q == MODE_NORMAL)
  ) else $error("short flag set outside normal mode");

  a_int_gate: assert property (
    (inhibit_q && $stable(inhibit_q)) |=> !INT
  ) else $error("interrupt raised while inhibited");

  c_tx_timeout:  cover property (tx_expired ##[1:1000] (tx_lock_q && !$past(tx_lock_q, 1)) or (tx_lock_q ##1 !tx_lock_q));
  c_rx_fault:    cover property (rx_fault);
  c_low_power_off_state_cycle: cover property (lp_enter ##[1:100] lp_exit);
  c_int_raised:  cover property ($rose(INT));

endmodule // ctf_ctrl
`default_nettype wire

// ==== ctf_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ctf_ctrl_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Transceiver side
  input  wire logic drv_en,
  input  wire logic rxd,
  output logic      txd,
  output logic      bus_dom,
  output logic      rxd_sense
);
  logic ext_dom;
  logic rx_stuck;
  initial begin
    txd      = 1'b1;
    ext_dom  = 1'b0;
    rx_stuck = 1'b0;
  end
  // Bus is dominant if any node drives it
  assign bus_dom   = drv_en | ext_dom;
  // Receive pin readback, optionally shorted high
  assign rxd_sense = rx_stuck | rxd;
  // Dominant request of n cycles, then released high
  task automatic dom(input int n);
    wait (rst == 1'b0);
    @(posedge clk);
    txd <= 1'b0;
    repeat (n) @(posedge clk);
    txd <= 1'b1;
    @(posedge clk);
  endtask
endmodule // ctf_ctrl_model
`default_nettype wire

// ==== can_transceiver_mode_fault_ctrl_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module can_transceiver_mode_fault_ctrl_test;
  import ctf_pkg::*;
  localparam int unsigned TO = 20;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             cyc = 1'b0;
  logic             stb = 1'b0;
  logic             we  = 1'b0;
  logic             low_power_off_state = 1'b0;
  logic [WB_AW-1:0] adr = '0;
  logic [WB_DW-1:0] dat_i = '0;
  logic [WB_DW-1:0] dat_o;
  logic             ack, txd, rxd_sense, rxd, txd_pd, rxd_pd, bus_dom, drv_en, rx_en, bus_pd, irq;
  ctf_short_t       shorts = '0;
  int               err_count = 0;
  int               n_tests = 0;
  int               sh;
  always #(CLK_PERIOD_NS / 2) clk = ~clk;
  ctf_ctrl #(.TX_TIMEOUT_CYC(TO), .BUS_TIMEOUT_CYC(TO)) ctf_ctrl_inst (
    .CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'hF), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .LOW_POWER_OFF_STATE(low_power_off_state), .TXD(txd), .RXD_SENSE(rxd_sense), .RXD(rxd),
    .TXD_PULLDOWN(txd_pd), .RXD_PULLDOWN(rxd_pd), .BUS_DOMINANT(bus_dom), .SHORTS(shorts),
    .DRV_EN(drv_en), .RX_EN(rx_en), .BUS_INPUT_PULLDOWN(bus_pd), .INT(irq));
  ctf_ctrl_model m (.clk(clk), .rst(rst), .drv_en(drv_en), .rxd(rxd), .txd(txd), .bus_dom(bus_dom),
    .rxd_sense(rxd_sense));
  function automatic logic [31:0] lp_mode(input int md);
    return (md == 0) ? 32'h0 : 32'h2;
  endfunction
  function automatic logic [31:0] short_flags(input int s);
    return 32'(s) << 3;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    dat_i <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 100);
    if (k >= 100) err_count++;
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // Dominant request; e is whether the driver should follow it
  task automatic pulse(input int n, input logic e);
    @(posedge clk);
    m.txd     <= 1'b0;
    m.ext_dom <= ~e;
    wait_n(1 + n);
    chk("drv_en", e, drv_en);
    chk("rxd", 1'b0, rxd);
    @(posedge clk);
    m.txd     <= 1'b1;
    m.ext_dom <= 1'b0;
    wait_n(2);
    chk("drv_off", 1'b0, drv_en);
    chk("rxd_high", 1'b1, rxd);
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'hF0B7));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdc("unmapped", 8'h10, 32'h0);
    wr(ADDR_CTRL, 32'h3);
    for (int i = 0; i < 6; i++) pulse(1 + $urandom_range(9), 1'b1);
    wr(ADDR_CTRL, 32'h1);
    for (int i = 0; i < 3; i++) pulse(1 + $urandom_range(9), 1'b0);
    // Transmit stuck low, then recovery
    wr(ADDR_CTRL, 32'h3);
    @(posedge clk);
    m.txd <= 1'b0;
    wait_n(TO + 5);
    chk("drv_to", 1'b0, drv_en);
    chk("rx_to", 1'b1, rx_en);
    rdc("st_tx", ADDR_STATUS, 32'h1);
    rdc("ctrl_tx", ADDR_CTRL, 32'h1);
    rdc("state_tx", ADDR_STATE, 32'h31);
    chk("int_mask", 1'b0, irq);
    wr(ADDR_MASK, 32'h7F);
    wait_n(1);
    chk("int_on", 1'b1, irq);
    wr(ADDR_CTRL, 32'h7);
    wait_n(1);
    chk("int_inh", 1'b0, irq);
    chk("drv_lock", 1'b0, drv_en);
    @(posedge clk);
    m.txd <= 1'b1;
    pulse(3, 1'b1);
    wr(ADDR_CTRL, 32'h3);
    wr(ADDR_STATUS, 32'h1);
    wait_n(1);
    chk("int_clr", 1'b0, irq);
    // Receive stuck high
    @(posedge clk);
    m.rx_stuck <= 1'b1;
    repeat (6) m.dom(2);
    rdc("st_rx6", ADDR_STATUS, 32'h0);
    m.dom(2);
    wait_n(1);
    chk("rx_off", 2'b00, {rx_en, drv_en});
    rdc("st_rx7", ADDR_STATUS, 32'h2);
    rdc("ctrl_rx", ADDR_CTRL, 32'h1);
    rdc("state_rx", ADDR_STATE, 32'h41);
    wr(ADDR_CTRL, 32'h3);
    wait_n(1);
    chk("rx_back", 1'b1, rx_en);
    wr(ADDR_STATUS, 32'h7F);
    // No supervision in sleep
    wr(ADDR_CTRL, 32'h0);
    repeat (7) m.dom(2);
    m.dom(TO + 5);
    rdc("st_sleep", ADDR_STATUS, 32'h0);
    m.rx_stuck <= 1'b0;
    // Bus held dominant in listen mode
    wr(ADDR_CTRL, 32'h1);
    m.ext_dom <= 1'b1;
    wait_n(TO + 5);
    @(posedge clk);
    m.ext_dom <= 1'b0;
    rdc("st_dom", ADDR_STATUS, 32'h4);
    wr(ADDR_STATUS, 32'h7F);
    shorts <= 4'hF;
    wait_n(3);
    @(posedge clk);
    shorts <= 4'h0;
    rdc("st_sh_lis", ADDR_STATUS, 32'h0);
    // Shorts in normal mode: informational only
    wr(ADDR_CTRL, 32'h3);
    sh = 1 + $urandom_range(14);
    shorts <= 4'(sh);
    pulse(2, 1'b1);
    @(posedge clk);
    shorts <= 4'h0;
    rdc("st_sh", ADDR_STATUS, short_flags(sh));
    chk("int_sh", 1'b0, irq);
    wr(ADDR_STATUS, 32'h7F);
    // Low-power-off entry and exit for every mode
    for (int md = 0; md < 4; md++) begin
      wr(ADDR_CTRL, 32'(md));
      low_power_off_state <= 1'b1;
      wait_n(3);
      chk("lp_pins", 6'b111000, {txd_pd, rxd_pd, bus_pd, drv_en, rx_en, rxd});
      wr(ADDR_CTRL, 32'h3);
      rdc("ctrl_lp", ADDR_CTRL, lp_mode(md));
      low_power_off_state <= 1'b0;
      wait_n(2);
      rdc("ctrl_after", ADDR_CTRL, 32'(md));
    end
    tally_and_finish();
  end
endmodule // can_transceiver_mode_fault_ctrl_test
`default_nettype wire
